// ==== inc/mprs_cfg.svh ====
// timing constants and the sleep control reset value for the power and reset sequencer
// assumes a 10 MHz standby-domain clock
`ifndef MPRS_CFG_SVH
`define MPRS_CFG_SVH

`define MPRS_CLK_HZ 10000000
// settle time after standby power before the automatic power-up, in microseconds
`define MPRS_SETTLE_US 1000
`define MPRS_SETTLE_CYC ((`MPRS_SETTLE_US * (`MPRS_CLK_HZ / 1000000)) < 1 ? 1 : (`MPRS_SETTLE_US * (`MPRS_CLK_HZ / 1000000)))
// long button press threshold, in milliseconds
`define MPRS_LONG_PRESS_MS 4000
`define MPRS_LONG_PRESS_CYC (`MPRS_LONG_PRESS_MS * (`MPRS_CLK_HZ / 1000))
// least reset hold time, in milliseconds
`define MPRS_RST_HOLD_MS 50
`define MPRS_RST_HOLD_CYC (`MPRS_RST_HOLD_MS * (`MPRS_CLK_HZ / 1000))
// debounce filter length, in microseconds
`define MPRS_DEBOUNCE_US 100
`define MPRS_DEBOUNCE_CYC ((`MPRS_DEBOUNCE_US * (`MPRS_CLK_HZ / 1000000)) < 1 ? 1 : (`MPRS_DEBOUNCE_US * (`MPRS_CLK_HZ / 1000000)))
// management bus clock limits, in kHz
`define MPRS_MGMT_BUS_MIN_KHZ 10
`define MPRS_MGMT_BUS_MAX_KHZ 100
// peripheral reset release delay after main rail good, in cycles
`define MPRS_PERIPH_DLY_CYC 1000
// sleep rail control reset value: high keeps the main rail off
`define MPRS_SLEEP_RST 1'b1

`endif

// ==== inc/mprs_pkg.sv ====
// types for the power and reset sequencer
package mprs_pkg;

    typedef enum logic [2:0] {
        MPRS_OFF,
        MPRS_SETTLE,
        MPRS_WAIT_GOOD,
        MPRS_ON,
        MPRS_STANDBY,
        MPRS_SOFT_OFF
    } mprs_state_t;

endpackage

// ==== inc/mprs_filt_if.sv ====
// carries one filtered input and its measured hold state between modules
// assumes a single clock domain
`timescale 1ns/10ps
`default_nettype none

interface mprs_filt_if;
    logic level;
    logic fall;
    logic rise;
    logic long_held;

    modport src (output level, output fall, output rise, output long_held);
    modport dst (input level, input fall, input rise, input long_held);
endinterface

`default_nettype wire

// ==== design/mprs_filter.sv ====
// two-flop synchroniser, debounce filter and low-time counter for one active-low input
// assumes the input is asynchronous to i_clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "mprs_cfg.svh"

module mprs_filter #(
    parameter int DEB_CYC = `MPRS_DEBOUNCE_CYC,
    parameter int LONG_CYC = 100
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_pin_n,
    mprs_filt_if.src o_filt
);
    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic [31:0] deb_cnt_q;
    logic [31:0] low_cnt_q;

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= i_pin_n;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // debounce: level changes only after a stable run
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_q <= 1'b1;
            deb_cnt_q <= 32'h0000_0000;
        end else if (sync2_q == level_q) begin
            deb_cnt_q <= 32'h0000_0000;
        end else if (deb_cnt_q >= 32'(DEB_CYC - 1)) begin
            level_q <= sync2_q;
            deb_cnt_q <= 32'h0000_0000;
        end else begin
            deb_cnt_q <= deb_cnt_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // low-time measure, saturating so a stuck pin cannot wrap
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt_q <= 32'h0000_0000;
        end else if (level_q) begin
            low_cnt_q <= 32'h0000_0000;
        end else if (low_cnt_q < 32'(LONG_CYC)) begin
            low_cnt_q <= low_cnt_q + 32'h0000_0001;
        end
    end

    assign o_filt.level = level_q;
    assign o_filt.fall = (sync2_q == 1'b0) && level_q && (deb_cnt_q >= 32'(DEB_CYC - 1));
    assign o_filt.rise = (sync2_q == 1'b1) && !level_q && (deb_cnt_q >= 32'(DEB_CYC - 1));
    assign o_filt.long_held = !level_q && (low_cnt_q >= 32'(LONG_CYC));
endmodule

`default_nettype wire

// ==== design/mprs_sequencer.sv ====
// power and reset sequencer of the module, standby clock domain
// assumes the standby rail powers this logic and i_rst_n is the standby power-on reset
//
// Notes on behaviour
// - power up automatically after settle time
// - standby first, then sleep control low (here both switch in the same cycle, on entering wait-good)
// - sleep control high means main off
// - short press standby, over 4s off
// - request drives sleep control high
// - 50 ms reset causes global reset
// - active-low peripheral reset output
// - two standby GPIOs live in off
// - bus 1 on only, bus 2 from wait-good on
// - overheat output asserted before shutdown
`timescale 1ns/10ps
`default_nettype none
`include "mprs_cfg.svh"

module mprs_sequencer #(
    parameter int SETTLE_CYC = `MPRS_SETTLE_CYC,
    parameter int LONG_PRESS_CYC = `MPRS_LONG_PRESS_CYC,
    parameter int RST_HOLD_CYC = `MPRS_RST_HOLD_CYC,
    parameter int DEBOUNCE_CYC = `MPRS_DEBOUNCE_CYC,
    parameter int PERIPH_DLY_CYC = `MPRS_PERIPH_DLY_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_power_button_n,
    input wire logic i_global_reset_in_n,
    input wire logic i_carrier_power_good,
    input wire logic i_overheat_n,
    output logic o_sleep_rail_control,
    output logic o_peripheral_reset_out_n,
    output logic o_overheat_alert_n,
    output logic o_overheat_alert_oe,
    output logic o_global_reset_n,
    output logic o_main_gpio_en,
    output logic o_standby_gpio_en,
    output logic o_main_mgmt_bus_en,
    output logic o_standby_mgmt_bus_en,
    output logic [2:0] o_state
);
    mprs_pkg::mprs_state_t state_q;
    mprs_pkg::mprs_state_t state_d;
    logic [31:0] settle_cnt_q;
    logic [31:0] periph_cnt_q;
    logic pg_q;
    logic sleep_q;
    logic periph_rst_n_q;
    logic glob_rst_n_q;
    logic oh_n_q;
    logic main_en_q;
    logic stby_en_q;
    logic rst_long_seen_q;
    logic btn_long_done_q;

    mprs_filt_if btn_if ();
    mprs_filt_if rst_if ();

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    // sync and debounce
    mprs_filter #(
        .DEB_CYC(DEBOUNCE_CYC),
        .LONG_CYC(LONG_PRESS_CYC)
    ) u_btn_filter (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_pin_n(i_power_button_n),
        .o_filt(btn_if.src)
    );

    mprs_filter #(
        .DEB_CYC(DEBOUNCE_CYC),
        .LONG_CYC(RST_HOLD_CYC)
    ) u_rst_filter (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_pin_n(i_global_reset_in_n),
        .o_filt(rst_if.src)
    );

    // power good treated as a synchronous level; one register stage for timing only
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pg_q <= 1'b0;
        end else begin
            pg_q <= i_carrier_power_good;
        end
    end

    // ------------------------------------------------------------
    // reset hold qualification
    // ------------------------------------------------------------
    // hold at least 50 ms
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_long_seen_q <= 1'b0;
        end else if (rst_if.long_held) begin
            rst_long_seen_q <= 1'b1;
        end else if (rst_if.level) begin
            rst_long_seen_q <= 1'b0;
        end
    end

    // the long-press decision fires once, while still held; release then is ignored
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            btn_long_done_q <= 1'b0;
        end else if (btn_if.level) begin
            btn_long_done_q <= 1'b0;
        end else if (btn_if.long_held) begin
            btn_long_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // settle counter
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_cnt_q <= 32'h0000_0000;
        end else if (state_q == mprs_pkg::MPRS_SETTLE) begin
            settle_cnt_q <= settle_cnt_q + 32'h0000_0001;
        end else begin
            settle_cnt_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            mprs_pkg::MPRS_OFF: begin
                state_d = mprs_pkg::MPRS_SETTLE;
            end
            mprs_pkg::MPRS_SETTLE: begin
                if (settle_cnt_q >= 32'(SETTLE_CYC - 1)) begin
                    state_d = mprs_pkg::MPRS_WAIT_GOOD;
                end
            end
            mprs_pkg::MPRS_WAIT_GOOD: begin
                if (pg_q) begin
                    state_d = mprs_pkg::MPRS_ON;
                end
            end
            mprs_pkg::MPRS_ON: begin
                if (btn_if.long_held && !btn_long_done_q) begin
                    state_d = mprs_pkg::MPRS_SOFT_OFF;
                end else if (btn_if.rise && !btn_long_done_q) begin
                    state_d = mprs_pkg::MPRS_STANDBY;
                end else if (!pg_q) begin
                    state_d = mprs_pkg::MPRS_WAIT_GOOD;
                end
            end
            mprs_pkg::MPRS_STANDBY, mprs_pkg::MPRS_SOFT_OFF: begin
                if (btn_if.fall) begin
                    state_d = mprs_pkg::MPRS_WAIT_GOOD;
                end
            end
            default: begin
                state_d = mprs_pkg::MPRS_OFF;
            end
        endcase
        if (rst_long_seen_q && rst_if.rise) begin
            state_d = mprs_pkg::MPRS_OFF;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= mprs_pkg::MPRS_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // main rail control
    // ------------------------------------------------------------
    // low only when on or waiting for power good
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sleep_q <= `MPRS_SLEEP_RST;
        end else begin
            sleep_q <= !(state_d == mprs_pkg::MPRS_ON || state_d == mprs_pkg::MPRS_WAIT_GOOD);
        end
    end

    // ------------------------------------------------------------
    // resets
    // ------------------------------------------------------------
    // global reset once held past the hold time, and through off and settle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            glob_rst_n_q <= 1'b0;
        end else begin
            glob_rst_n_q <= !(rst_long_seen_q || state_d == mprs_pkg::MPRS_OFF
                || state_d == mprs_pkg::MPRS_SETTLE);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            periph_cnt_q <= 32'h0000_0000;
            periph_rst_n_q <= 1'b0;
        end else if (state_q != mprs_pkg::MPRS_ON || rst_long_seen_q) begin
            periph_cnt_q <= 32'h0000_0000;
            periph_rst_n_q <= 1'b0;
        end else if (periph_cnt_q >= 32'(PERIPH_DLY_CYC - 1)) begin
            periph_rst_n_q <= 1'b1;
        end else begin
            periph_cnt_q <= periph_cnt_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // overheat alert, open drain: drive low only
    // ------------------------------------------------------------
    // assert on overheat
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oh_n_q <= 1'b1;
        end else begin
            oh_n_q <= i_overheat_n;
        end
    end

    // ------------------------------------------------------------
    // interface enables by power state
    // ------------------------------------------------------------
    // fully-on only
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            main_en_q <= 1'b0;
        end else begin
            main_en_q <= (state_d == mprs_pkg::MPRS_ON);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stby_en_q <= 1'b0;
        end else begin
            stby_en_q <= (state_d != mprs_pkg::MPRS_OFF && state_d != mprs_pkg::MPRS_SETTLE);
        end
    end

    assign o_sleep_rail_control = sleep_q;
    assign o_peripheral_reset_out_n = periph_rst_n_q;
    assign o_overheat_alert_n = 1'b0;
    assign o_overheat_alert_oe = !oh_n_q;
    assign o_global_reset_n = glob_rst_n_q;
    assign o_main_gpio_en = main_en_q;
    assign o_main_mgmt_bus_en = main_en_q;
    assign o_standby_gpio_en = stby_en_q;
    assign o_standby_mgmt_bus_en = stby_en_q;
    assign o_state = state_q;
endmodule

`default_nettype wire

// ==== bench/mprs_seq_sva.sv ====
// checker on the sequencer top ports
// assumes one clock domain and small bench counts
`timescale 1ns/10ps
`default_nettype none

module mprs_seq_sva #(
    parameter int SETTLE_CYC = 4,
    parameter int LONG_PRESS_CYC = 50,
    parameter int RST_HOLD_CYC = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_power_button_n,
    input wire logic i_global_reset_in_n,
    input wire logic i_carrier_power_good,
    input wire logic i_overheat_n,
    input wire logic o_sleep_rail_control,
    input wire logic o_peripheral_reset_out_n,
    input wire logic o_overheat_alert_n,
    input wire logic o_overheat_alert_oe,
    input wire logic o_global_reset_n,
    input wire logic o_main_gpio_en,
    input wire logic o_standby_gpio_en,
    input wire logic o_main_mgmt_bus_en,
    input wire logic o_standby_mgmt_bus_en,
    input wire logic [2:0] o_state
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // raw low times, a ceiling for filtered ones; settle-state length
    // ----------------------------------------
    int set_q;
    int btn_q;
    int rst_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            set_q <= 0;
            btn_q <= 0;
            rst_q <= 0;
        end else begin
            set_q <= (o_state == 3'h1) ? set_q + 1 : 0;
            btn_q <= i_power_button_n ? 0 : btn_q + 1;
            rst_q <= i_global_reset_in_n ? 0 : rst_q + 1;
        end
    end
    chk_auto_start: assert property (o_state == 3'h0 |=> o_state == 3'h1)
        else $error("no start from off");
    chk_settle_len: assert property (o_state == 3'h2 && $past(o_state) == 3'h1 |-> set_q == SETTLE_CYC)
        else $error("settle length wrong");
    chk_sleep_level: assert property (o_sleep_rail_control == !(o_state inside {3'h2, 3'h3}))
        else $error("sleep control wrong");
    chk_good_to_on: assert property ((o_state == 3'h2 && i_carrier_power_good) [*2] |-> ##[0:2] o_state == 3'h3)
        else $error("no on after good");
    chk_long_press: assert property (o_state == 3'h5 && $past(o_state) != 3'h5 |-> btn_q >= LONG_PRESS_CYC)
        else $error("off too early");
    chk_short_press: assert property (o_state == 3'h4 && $past(o_state) == 3'h3 |-> btn_q == 0)
        else $error("standby while held");
    chk_glob_hold: assert property ($fell(o_global_reset_n) |-> rst_q >= RST_HOLD_CYC)
        else $error("global reset too soon");
    chk_periph_low: assert property (o_state != 3'h3 && $past(o_state) != 3'h3 |-> !o_peripheral_reset_out_n)
        else $error("peripheral reset off");
    chk_main_en: assert property (o_main_gpio_en == (o_state == 3'h3) && o_main_mgmt_bus_en == o_main_gpio_en)
        else $error("main enables wrong");
    chk_stby_en: assert property ((o_standby_mgmt_bus_en == (o_state inside {[3'h2:3'h5]}))
        && (o_standby_gpio_en == o_standby_mgmt_bus_en))
        else $error("standby enables wrong");
    chk_overheat_out: assert property ($past(i_rst_n) |-> o_overheat_alert_oe == !$past(i_overheat_n))
        else $error("overheat output wrong");
    cover property (o_state == 3'h4);
    cover property (o_state == 3'h5);
    cover property ($fell(o_global_reset_n) && o_state == 3'h3);
endmodule

bind mprs_sequencer mprs_seq_sva #(
    .SETTLE_CYC(SETTLE_CYC),
    .LONG_PRESS_CYC(LONG_PRESS_CYC),
    .RST_HOLD_CYC(RST_HOLD_CYC)
) u_sva (.*);

`default_nettype wire

// ==== bench/mprs_carrier.sv ====
// carrier model: main rail and its power good
// assumes the rail is switched by the sleep control
`timescale 1ns/10ps
`default_nettype none

module mprs_carrier #(
    parameter int PG_DLY = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_sleep_rail_control,
    input wire logic i_fail,
    output logic o_power_good
);
    int cnt_q = 0;
    // rail ramps on low, standby stays
    always_ff @(posedge i_clk_sys) begin
        if (i_sleep_rail_control) begin
            cnt_q <= 0;
        end else if (cnt_q < PG_DLY) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign o_power_good = !i_fail && cnt_q == PG_DLY;
endmodule

`default_nettype wire

// ==== bench/module_power_reset_sequencer_bench.sv ====
// bench for the sequencer with a carrier model
// assumes design and include folders on the path
`timescale 1ns/10ps
`default_nettype none

module module_power_reset_sequencer_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic btn_n = 1'b1;
    logic grst_n = 1'b1;
    logic ovh_n = 1'b1;
    logic pg_fail = 1'b0;
    logic ovh_live = 1'b0;
    logic pg, sleep, prst_n, od_n, oe, glob_n, mge, sge, mme, sme;
    logic [2:0] st;
    logic [31:0] seed = 32'h0000_7ae4;
    int failures = 0;
    int samples_checked = 0;

    always #50 i_clk_sys = ~i_clk_sys;

    mprs_carrier u_car (
        .i_clk_sys(i_clk_sys),
        .i_sleep_rail_control(sleep),
        .i_fail(pg_fail),
        .o_power_good(pg)
    );

    mprs_sequencer #(
        .SETTLE_CYC(4),
        .LONG_PRESS_CYC(50),
        .RST_HOLD_CYC(20),
        .DEBOUNCE_CYC(2),
        .PERIPH_DLY_CYC(3)
    ) u_dut (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_power_button_n(btn_n),
        .i_global_reset_in_n(grst_n),
        .i_carrier_power_good(pg),
        .i_overheat_n(ovh_n),
        .o_sleep_rail_control(sleep),
        .o_peripheral_reset_out_n(prst_n),
        .o_overheat_alert_n(od_n),
        .o_overheat_alert_oe(oe),
        .o_global_reset_n(glob_n),
        .o_main_gpio_en(mge),
        .o_standby_gpio_en(sge),
        .o_main_mgmt_bus_en(mme),
        .o_standby_mgmt_bus_en(sme),
        .o_state(st)
    );

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [4:0] exp_outs(input logic [2:0] s);
        logic on;
        logic up;
        on = s == 3'h3;
        up = s inside {[3'h2:3'h5]};
        return {!(s inside {3'h2, 3'h3}), on, on, up, up};
    endfunction

    task chk(input string nm, input logic [4:0] seen, input logic [4:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task pause(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    task press(input int n);
        btn_n = 1'b0;
        pause(n);
        btn_n = 1'b1;
    endtask

    task wait_st(input logic [2:0] s);
        int n;
        n = 0;
        while (st !== s && n < 400) begin
            pause(1);
            n++;
        end
        chk("state", {2'h0, st}, {2'h0, s});
        chk("rails", {sleep, mge, mme, sge, sme}, exp_outs(s));
    endtask

    // overheat drawn each cycle; output lags one clock
    always @(negedge i_clk_sys) begin
        if (ovh_live && i_rst_n) chk("overheat", {3'h0, od_n, oe}, {4'h0, !ovh_n});
        ovh_live = i_rst_n;
        ovh_n = |(xs() & 32'h0000_0003);
    end

    initial begin
        #1000000;
        failures++;
        final_report();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        wait_st(3'h3);
        pause(10);
        chk("periph", {3'h0, prst_n, glob_n}, 5'h03);
        for (int i = 0; i < 4; i++) begin
            press(8 + int'(xs() % 30));
            wait_st(3'h4);
            pause(3);
            chk("periph", {4'h0, prst_n}, 5'h00);
            press(6);
            wait_st(3'h2);
            wait_st(3'h3);
        end
        btn_n = 1'b0;
        wait_st(3'h5);
        btn_n = 1'b1;
        pause(20);
        chk("state", {2'h0, st}, 5'h05);
        press(6);
        wait_st(3'h3);
        grst_n = 1'b0;
        pause(8);
        grst_n = 1'b1;
        pause(20);
        chk("short reset", {1'b0, glob_n, st}, 5'h0b);
        grst_n = 1'b0;
        pause(40);
        chk("long reset", {3'h0, glob_n, prst_n}, 5'h00);
        grst_n = 1'b1;
        wait_st(3'h0);
        wait_st(3'h3);
        pg_fail = 1'b1;
        wait_st(3'h2);
        pause(2);
        chk("periph", {4'h0, prst_n}, 5'h00);
        pg_fail = 1'b0;
        wait_st(3'h3);
        final_report();
    end
endmodule

`default_nettype wire
